// ### core/rim_regs.svh
`ifndef RIM_REGS_SVH
`define RIM_REGS_SVH

// Inputs and counters
`define RIM_NBITS    54
`define RIM_CNT_MAX  8'hFF
// Timebase
`define RIM_TB_MIN   16'h039A
`define RIM_TB_DEF   16'h2400
`define RIM_XTAL_HZ  11059200
`define RIM_XTAL_DIV 12
`define RIM_CLK_HZ   20000000
// Serial line
`define RIM_OVS      16
`define RIM_CR       7'h0D
`define RIM_BAUD_0   1200
`define RIM_BAUD_1   2400
`define RIM_BAUD_2   4800
`define RIM_BAUD_3   9600
`define RIM_BAUD_4   14400
`define RIM_BAUD_5   19200
`define RIM_BAUD_6   28800
`define RIM_BAUD_7   57600
// Watchdog timeout in ms
`define RIM_WDOG_MS  1000
// Register byte addresses
`define RIM_A_IN_LO  8'h00
`define RIM_A_IN_HI  8'h04
`define RIM_A_COS_LO 8'h08
`define RIM_A_COS_HI 8'h0C
`define RIM_A_EDG_LO 8'h10
`define RIM_A_EDG_HI 8'h14
`define RIM_A_CNT    8'h18
`define RIM_A_FLAG   8'h1C
`define RIM_A_TB     8'h20
`define RIM_A_ADDR   8'h24
`define RIM_A_BAUD   8'h28
`define RIM_A_DATA   8'h2C
`define RIM_A_STAT   8'h30
`define RIM_A_ISTAT  8'h34
`define RIM_A_IMASK  8'h38
`define RIM_A_KICK   8'h3C
`define RIM_A_HLO    8'h40
`define RIM_A_HHI    8'h44
// Field positions
`define RIM_CNT_CLR1 8
`define RIM_CNT_CLRA 9

`endif

// ### core/rim_pkg.sv
`default_nettype none
`include "rim_regs.svh"
package rim_pkg;
  typedef logic [`RIM_NBITS-1:0] rim_bits_t;
  typedef enum logic [1:0] {
    RIM_RX_IDLE  = 2'h0,
    RIM_RX_START = 2'h1,
    RIM_RX_DATA  = 2'h3,
    RIM_RX_STOP  = 2'h2
  } rim_rx_t;
endpackage
`default_nettype wire

// ### core/rim_uart.sv
`timescale 1ns/100ps
`default_nettype none
`include "rim_regs.svh"
module rim_uart (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Oversample enable
  input  wire logic       ovs_en,
  // Line
  input  wire logic       rx_pin,
  output logic            tx_pin,
  output logic            tx_de,
  // Transmit side
  input  wire logic       tx_valid,
  input  wire logic [6:0] tx_char,
  output logic            tx_ready,
  // Receive side
  output logic            rx_valid,
  output logic [6:0]      rx_char,
  output logic            rx_perr
);
  import rim_pkg::*;

  logic [2:0] sy, next_sy;
  logic       lvl, next_lvl;
  rim_rx_t    st, next_st;
  logic [3:0] ph, next_ph;
  logic [3:0] bn, next_bn;
  logic [7:0] sh, next_sh;
  logic       next_rx_valid, next_rx_perr;
  logic [6:0] next_rx_char;
  logic [9:0] tsh, next_tsh;
  logic [3:0] tbits, next_tbits;
  logic [3:0] tph, next_tph;

  // Half duplex: no transmit start while a character is arriving
  assign tx_ready = (tbits == 4'h0) && (st == RIM_RX_IDLE); // RQ10
  assign tx_de    = tbits != 4'h0; // RQ10
  assign tx_pin   = tsh[0];

  always_comb begin
    next_sy = {sy[1:0], rx_pin};
    next_lvl = (sy[2] == sy[1]) ? sy[2] : lvl;
    next_st = st;
    next_ph = ph;
    next_bn = bn;
    next_sh = sh;
    next_rx_valid = 1'b0;
    next_rx_char = rx_char;
    next_rx_perr = rx_perr;
    if (ovs_en) begin
      next_ph = ph + 4'h1;
      case (st)
        RIM_RX_IDLE: begin
          next_ph = 4'h0;
          if (!lvl && tbits == 4'h0)
            next_st = RIM_RX_START;
        end
        RIM_RX_START: if (ph == 4'h7) begin
          next_ph = 4'h0;
          next_bn = 4'h0;
          next_st = lvl ? RIM_RX_IDLE : RIM_RX_DATA;
        end
        RIM_RX_DATA: if (ph == 4'hF) begin
          next_sh = {lvl, sh[7:1]};
          next_bn = bn + 4'h1;
          if (bn == 4'h7)
            next_st = RIM_RX_STOP;
        end
        RIM_RX_STOP: if (ph == 4'hF) begin
          // Seven data bits, even parity, one stop bit
          next_rx_valid = 1'b1; // RQ14
          next_rx_char = sh[6:0];
          next_rx_perr = (^sh) | ~lvl; // RQ14
          next_st = RIM_RX_IDLE;
        end
        default: next_st = RIM_RX_IDLE;
      endcase
    end
    next_tsh = tsh;
    next_tbits = tbits;
    next_tph = tph;
    if (tx_valid && tx_ready) begin
      next_tsh = {1'b1, ^tx_char, tx_char, 1'b0}; // RQ14
      next_tbits = 4'hA;
      next_tph = 4'h0;
    end else if (ovs_en && tbits != 4'h0) begin
      next_tph = tph + 4'h1;
      if (tph == 4'hF) begin
        next_tsh = {1'b1, tsh[9:1]};
        next_tbits = tbits - 4'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sy <= 3'h7;
      lvl <= 1'b1;
      st <= RIM_RX_IDLE;
      ph <= 4'h0;
      bn <= 4'h0;
      sh <= 8'h00;
      rx_valid <= 1'b0;
      rx_char <= 7'h00;
      rx_perr <= 1'b0;
      tsh <= 10'h3FF;
      tbits <= 4'h0;
      tph <= 4'h0;
    end else begin
      sy <= next_sy;
      lvl <= next_lvl;
      st <= next_st;
      ph <= next_ph;
      bn <= next_bn;
      sh <= next_sh;
      rx_valid <= next_rx_valid;
      rx_char <= next_rx_char;
      rx_perr <= next_rx_perr;
      tsh <= next_tsh;
      tbits <= next_tbits;
      tph <= next_tph;
    end
  end

  chk_tx_parity: assert property (@(posedge hclk) disable iff (!hresetn) // RQ14
    tx_valid && tx_ready |=> tsh[8] == ^tsh[7:1] && !tsh[0] && tsh[9])
    else $error("transmit frame not 7E1");
endmodule // rim_uart
`default_nettype wire

// ### core/rim_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "rim_regs.svh"
// Function
// RQ1: 54 input levels readable as single bits or 8-bit bytes.
// RQ2: Per-input counter bumps on selected active edge, at most 255.
// RQ3: Any counter can be read back and reset by command.
// RQ4: Level change on an enabled input sets the change flag.
// RQ5: Change detection enabled per input bit by a mask.
// RQ6: Unit address 00..FF kept in storage, loaded at power-on.
// RQ7: Eight baud rates 1200..57600, kept in storage, applied at power-on.
// RQ8: One programmable timebase drives sampling, 14 Hz to 1 kHz.
// RQ9: Watchdog resets the unit when it is no longer serviced.
// RQ10: Shared half-duplex line; unit replies only after a command.
// RQ11: Host addresses up to 31 units on one multidrop pair.
// RQ12: ASCII commands in, one ASCII response per command out.
// RQ13: Input data stored locally for later retrieval by the host.
// RQ14: Characters are 7 data bits, even parity, one stop bit.
// RQ15: Address 00 means non-addressed mode, else addressed mode.
// RQ16: Reading the change flag reports it and then clears it.
// RQ17: Tick = 11059200/12/timebase; below 039A falls back to 2400.
// RQ18: Edges from successive samples; counters saturate at 255.
module rim_core #(
  parameter int unsigned WDOG_CYCLES = `RIM_WDOG_MS * (`RIM_CLK_HZ / 1000),
  parameter int unsigned HIST_DEPTH  = 8
) (
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // Digital inputs
  input  wire rim_pkg::rim_bits_t din,
  // Serial line
  input  wire logic               line_rx,
  output logic                    line_tx,
  output logic                    line_de,
  // Non-volatile storage
  input  wire logic [7:0]         nv_addr,
  input  wire logic [2:0]         nv_baud,
  input  wire logic [15:0]        nv_tbase,
  output logic                    nv_we,
  output logic [7:0]              stored_addr,
  output logic [2:0]              stored_baud,
  output logic [15:0]             stored_tbase,
  // Interrupt and watchdog
  output logic                    irq,
  output logic                    wdog_reset
);
  import rim_pkg::*;

  localparam int HW = $clog2(HIST_DEPTH);
  localparam logic [24:0] CLK_MOD = 25'(`RIM_CLK_HZ);
  localparam logic [24:0] REF_INC = 25'(`RIM_XTAL_HZ / `RIM_XTAL_DIV);
  localparam logic [31:0] WD_LAST = 32'(WDOG_CYCLES - 1);

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Bus, config and flag state
  logic [7:0]  wa, next_wa;
  logic        we, next_we, next_nv_we, loaded;
  logic [31:0] next_hrdata;
  rim_bits_t   cos_en, next_cos_en, edge_sel, next_edge_sel;
  logic [5:0]  cnt_sel, next_cnt_sel;
  logic [2:0]  stat, next_stat, mask, next_mask;
  logic        flag, next_flag, rx_full, next_rx_full;
  logic        reply_ok, next_reply_ok;
  logic [6:0]  rx_buf, next_rx_buf;
  logic [7:0]  next_addr;
  logic [2:0]  next_baud;
  logic [15:0] next_tbase, tb_eff;
  logic        ap, rd_ap, wr_data, clr_one, clr_all, kick, flag_set;
  logic        tx_valid, tx_ready, rx_valid, rx_perr;
  logic [6:0]  rx_char;
  // Input sampling
  rim_bits_t   s1, s2, s3, filt, cur, chg, act;
  rim_bits_t   next_s3, next_filt, next_cur;
  logic        primed, next_primed;
  logic [7:0]  cnt [`RIM_NBITS];
  // Timebase, baud and watchdog
  logic [24:0] tb_acc, next_tb_acc, bd_acc, next_bd_acc, bd_inc;
  logic [24:0] tb_sum, bd_sum;
  logic [15:0] tb_cnt, next_tb_cnt;
  logic        tick, next_tick, baud_en, next_baud_en, next_wdog;
  logic [31:0] wd, next_wd;
  // History
  rim_bits_t   hist [HIST_DEPTH];
  logic [HW-1:0] wp, next_wp, rp, next_rp;
  logic [HW:0] hcnt, next_hcnt;
  logic        h_push, h_pop;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap        = hsel & htrans[1] & hready;
  assign rd_ap     = ap & ~hwrite;
  assign wr_data   = we && wa == `RIM_A_DATA;
  assign tx_valid  = wr_data && reply_ok; // RQ10
  assign clr_one   = we && wa == `RIM_A_CNT && hwdata[`RIM_CNT_CLR1];
  assign clr_all   = we && wa == `RIM_A_CNT && hwdata[`RIM_CNT_CLRA];
  assign kick      = we && wa == `RIM_A_KICK;
  assign tb_eff    = (stored_tbase < `RIM_TB_MIN) ? `RIM_TB_DEF
                                                  : stored_tbase; // RQ17
  assign chg       = (filt ^ cur) & {`RIM_NBITS{tick & primed}}; // RQ18
  assign act       = chg & ~(filt ^ edge_sel); // RQ2
  assign flag_set  = |(chg & cos_en); // RQ4 RQ5
  assign h_push    = (|chg) && hcnt != (HW + 1)'(HIST_DEPTH); // RQ13
  assign h_pop     = rd_ap && haddr[7:0] == `RIM_A_HHI && hcnt != '0;
  assign irq       = |(stat & mask);

  rim_uart u_uart (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ovs_en   (baud_en),
    .rx_pin   (line_rx),
    .tx_pin   (line_tx),
    .tx_de    (line_de),
    .tx_valid (tx_valid),
    .tx_char  (hwdata[6:0]),
    .tx_ready (tx_ready),
    .rx_valid (rx_valid),
    .rx_char  (rx_char),
    .rx_perr  (rx_perr)
  );

  // Read data is registered in the address phase, so reads add no wait
  always_comb begin
    next_hrdata = hrdata;
    if (rd_ap) begin
      case (haddr[7:0])
        `RIM_A_IN_LO:  next_hrdata = cur[31:0]; // RQ1
        `RIM_A_IN_HI:  next_hrdata = {10'h000, cur[53:32]}; // RQ1
        `RIM_A_COS_LO: next_hrdata = cos_en[31:0];
        `RIM_A_COS_HI: next_hrdata = {10'h000, cos_en[53:32]};
        `RIM_A_EDG_LO: next_hrdata = edge_sel[31:0];
        `RIM_A_EDG_HI: next_hrdata = {10'h000, edge_sel[53:32]};
        `RIM_A_CNT:    next_hrdata = (cnt_sel < 6'(`RIM_NBITS)) ?
          {15'h0000, cur[cnt_sel], 2'h0, cnt_sel, cnt[cnt_sel]} // RQ1 RQ3
          : {18'h00000, cnt_sel, 8'h00};
        `RIM_A_FLAG:   next_hrdata = {31'h00000000, flag}; // RQ16
        `RIM_A_TB:     next_hrdata = {16'h0000, stored_tbase};
        `RIM_A_ADDR:   next_hrdata = {24'h000000, stored_addr};
        `RIM_A_BAUD:   next_hrdata = {29'h00000000, stored_baud};
        `RIM_A_DATA:   next_hrdata = {25'h0000000, rx_buf}; // RQ12
        `RIM_A_STAT:   next_hrdata = {28'h0000000, stored_addr != 8'h00,
                                      reply_ok, ~tx_ready, rx_full}; // RQ15
        `RIM_A_ISTAT:  next_hrdata = {29'h00000000, stat};
        `RIM_A_IMASK:  next_hrdata = {29'h00000000, mask};
        `RIM_A_HLO:    next_hrdata = hist[rp][31:0];
        `RIM_A_HHI:    next_hrdata = {hcnt != '0, 9'h000, hist[rp][53:32]};
        default:       next_hrdata = 32'h00000000;
      endcase
    end
  end

  always_comb begin
    next_wa = ap ? haddr[7:0] : wa;
    next_we = ap & hwrite;
    next_nv_we = 1'b0;
    next_cos_en = cos_en;
    next_edge_sel = edge_sel;
    next_cnt_sel = cnt_sel;
    next_addr = stored_addr;
    next_baud = stored_baud;
    next_tbase = stored_tbase;
    next_mask = mask;
    if (!loaded) begin
      next_addr = nv_addr; // RQ6
      next_baud = nv_baud; // RQ7
      next_tbase = nv_tbase; // RQ8
    end else if (we) begin
      case (wa)
        `RIM_A_COS_LO: next_cos_en[31:0] = hwdata; // RQ5
        `RIM_A_COS_HI: next_cos_en[53:32] = hwdata[21:0]; // RQ5
        `RIM_A_EDG_LO: next_edge_sel[31:0] = hwdata;
        `RIM_A_EDG_HI: next_edge_sel[53:32] = hwdata[21:0];
        `RIM_A_CNT:    next_cnt_sel = hwdata[5:0];
        `RIM_A_IMASK:  next_mask = hwdata[2:0];
        `RIM_A_ADDR: begin
          next_addr = hwdata[7:0]; // RQ6
          next_nv_we = 1'b1;
        end
        `RIM_A_BAUD: begin
          next_baud = hwdata[2:0]; // RQ7
          next_nv_we = 1'b1;
        end
        `RIM_A_TB: begin
          next_tbase = hwdata[15:0]; // RQ8
          next_nv_we = 1'b1;
        end
        default: next_mask = mask;
      endcase
    end
  end

  // Flags: a set in the clearing cycle wins
  always_comb begin
    next_flag = flag_set |
      (flag & ~(rd_ap && haddr[7:0] == `RIM_A_FLAG)); // RQ16
    next_rx_full = rx_valid |
      (rx_full & ~(rd_ap && haddr[7:0] == `RIM_A_DATA));
    next_rx_buf = rx_valid ? rx_char : rx_buf;
    next_stat = {rx_valid & rx_perr, rx_valid, flag_set} |
      (stat & ~((we && wa == `RIM_A_ISTAT) ? hwdata[2:0] : 3'h0));
    next_reply_ok = reply_ok;
    if (tx_valid && tx_ready && hwdata[6:0] == `RIM_CR)
      next_reply_ok = 1'b0; // RQ10 RQ12
    if (rx_valid && !rx_perr && rx_char == `RIM_CR)
      next_reply_ok = 1'b1; // RQ10 RQ12
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wa <= 8'h00;
      we <= 1'b0;
      hrdata <= 32'h00000000;
      nv_we <= 1'b0;
      loaded <= 1'b0;
      cos_en <= '0;
      edge_sel <= '1;
      cnt_sel <= 6'h00;
      stored_addr <= 8'h00;
      stored_baud <= 3'h3;
      stored_tbase <= `RIM_TB_DEF;
      mask <= 3'h0;
      flag <= 1'b0;
      rx_full <= 1'b0;
      rx_buf <= 7'h00;
      stat <= 3'h0;
      reply_ok <= 1'b0;
    end else begin
      wa <= next_wa;
      we <= next_we;
      hrdata <= next_hrdata;
      nv_we <= next_nv_we;
      loaded <= 1'b1;
      cos_en <= next_cos_en;
      edge_sel <= next_edge_sel;
      cnt_sel <= next_cnt_sel;
      stored_addr <= next_addr;
      stored_baud <= next_baud;
      stored_tbase <= next_tbase;
      mask <= next_mask;
      flag <= next_flag;
      rx_full <= next_rx_full;
      rx_buf <= next_rx_buf;
      stat <= next_stat;
      reply_ok <= next_reply_ok;
    end
  end

  // Inputs: change accepted when second and third stage agree
  always_comb begin
    next_s3 = s2;
    next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
    next_cur = tick ? filt : cur; // RQ8 RQ18
    next_primed = primed | tick;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
      cur <= '0;
      primed <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= next_s3;
      filt <= next_filt;
      cur <= next_cur;
      primed <= next_primed;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `RIM_NBITS; g++) begin : g_cnt
      logic [7:0] next_c;
      always_comb begin
        next_c = cnt[g];
        if (clr_all || (clr_one && hwdata[5:0] == 6'(g)))
          next_c = 8'h00; // RQ3
        else if (act[g] && cnt[g] != `RIM_CNT_MAX)
          next_c = cnt[g] + 8'h01; // RQ2 RQ18
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          cnt[g] <= 8'h00;
        else
          cnt[g] <= next_c;
      end
    end
  endgenerate

  // Timebase, baud enable and watchdog
  always_comb begin
    case (stored_baud)
      3'h0: bd_inc = 25'(`RIM_BAUD_0 * `RIM_OVS);
      3'h1: bd_inc = 25'(`RIM_BAUD_1 * `RIM_OVS);
      3'h2: bd_inc = 25'(`RIM_BAUD_2 * `RIM_OVS);
      3'h3: bd_inc = 25'(`RIM_BAUD_3 * `RIM_OVS);
      3'h4: bd_inc = 25'(`RIM_BAUD_4 * `RIM_OVS);
      3'h5: bd_inc = 25'(`RIM_BAUD_5 * `RIM_OVS);
      3'h6: bd_inc = 25'(`RIM_BAUD_6 * `RIM_OVS);
      default: bd_inc = 25'(`RIM_BAUD_7 * `RIM_OVS); // RQ7
    endcase
    tb_sum = tb_acc + REF_INC;
    bd_sum = bd_acc + bd_inc;
    next_tb_acc = (tb_sum >= CLK_MOD) ? tb_sum - CLK_MOD : tb_sum;
    next_bd_acc = (bd_sum >= CLK_MOD) ? bd_sum - CLK_MOD : bd_sum;
    next_baud_en = bd_sum >= CLK_MOD;
    next_tb_cnt = tb_cnt;
    next_tick = 1'b0;
    if (tb_sum >= CLK_MOD) begin
      next_tb_cnt = tb_cnt + 16'h0001;
      if (tb_cnt >= tb_eff - 16'h0001) begin
        next_tb_cnt = 16'h0000;
        next_tick = 1'b1; // RQ8 RQ17
      end
    end
    next_wdog = !kick && wd == WD_LAST; // RQ9
    next_wd = (kick || wd == WD_LAST) ? 32'h00000000 : wd + 32'h00000001;
    next_wp = h_push ? wp + HW'(1) : wp;
    next_rp = h_pop ? rp + HW'(1) : rp;
    next_hcnt = hcnt + (HW + 1)'(h_push) - (HW + 1)'(h_pop);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tb_acc <= '0;
      bd_acc <= '0;
      tb_cnt <= 16'h0000;
      tick <= 1'b0;
      baud_en <= 1'b0;
      wd <= 32'h00000000;
      wdog_reset <= 1'b0;
      wp <= '0;
      rp <= '0;
      hcnt <= '0;
    end else begin
      tb_acc <= next_tb_acc;
      bd_acc <= next_bd_acc;
      tb_cnt <= next_tb_cnt;
      tick <= next_tick;
      baud_en <= next_baud_en;
      wd <= next_wd;
      wdog_reset <= next_wdog;
      wp <= next_wp;
      rp <= next_rp;
      hcnt <= next_hcnt;
    end
  end

  always_ff @(posedge hclk) begin
    if (h_push)
      hist[wp] <= filt; // RQ13
  end

  chk_flag_set: assert property (flag_set |=> flag) // RQ4
    else $error("change flag not set");
  chk_flag_clear: assert property (rd_ap && haddr[7:0] == `RIM_A_FLAG // RQ16
    && !flag_set ##1 !flag_set |=> hrdata[0] == $past(flag, 2) && !flag)
    else $error("flag read did not report then clear");
  chk_cnt_inc: assert property (act[0] && !clr_one && !clr_all // RQ2
    && cnt[0] < `RIM_CNT_MAX |=> cnt[0] == $past(cnt[0]) + 8'h01)
    else $error("counter missed an edge");
  chk_cnt_sat: assert property (cnt[0] == `RIM_CNT_MAX && !clr_all // RQ18
    && !clr_one |=> cnt[0] == `RIM_CNT_MAX)
    else $error("counter wrapped");
  chk_cnt_clear: assert property (clr_all |=> cnt[0] == 8'h00) // RQ3
    else $error("counter not reset");
  chk_tb_floor: assert property (stored_tbase < `RIM_TB_MIN |-> // RQ17
    tb_eff == `RIM_TB_DEF) else $error("timebase fallback wrong");
  chk_reply_gate: assert property (line_de && !$past(line_de) |-> // RQ10
    $past(reply_ok)) else $error("reply without command");
  chk_wdog_fire: assert property (wd == WD_LAST && !kick |=> // RQ9
    wdog_reset ##1 !wdog_reset) else $error("watchdog did not fire");
  chk_nv_load: assert property ($rose(loaded) |-> // RQ6
    stored_addr == $past(nv_addr) && stored_baud == $past(nv_baud))
    else $error("power-on load wrong"); // RQ7
endmodule // rim_core
`default_nettype wire

// ### testbench/rim_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module rim_host_model #(
  parameter int BIT_NS = 17361
) (
  // Line
  input  wire logic line_tx,
  input  wire logic line_de,
  output logic      line_rx
);
  logic [6:0] got_char;
  logic [7:0] sh;
  int         got_cnt;
  int         bad_cnt;
  initial begin
    line_rx = 1'b1;
    got_cnt = 0;
    bad_cnt = 0;
  end
  // Frame one character LSB first; bad flips the parity bit
  task automatic send(input logic [6:0] c, input logic bad);
    logic [9:0] f;
    f = {1'b1, ^c ^ bad, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_rx = f[i];
      #(BIT_NS);
    end
  endtask
  // Decode what the unit sends while it owns the line
  always @(negedge line_tx) begin
    #(BIT_NS / 2);
    if (line_de === 1'b1) begin
      // Seven data bits and parity, then the stop bit and the parity are checked together
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        sh[i] = line_tx;
        if (line_de !== 1'b1) bad_cnt++;
      end
      #(BIT_NS);
      if (line_tx !== 1'b1 || ^sh !== 1'b0) bad_cnt++;
      got_char = sh[6:0];
      got_cnt++;
    end
  end
endmodule // rim_host_model
`default_nettype wire

// ### testbench/remote_input_monitor_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "rim_regs.svh"
module remote_input_monitor_tb_top;
  import rim_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic        hready, hreadyout, hresp;
  logic [31:0] hrdata, rd;
  rim_bits_t   din = 54'h20_0000_0000_0000;
  logic        line_rx, line_tx, line_de;
  logic        nv_we, irq, wdog_reset;
  logic [7:0]  stored_addr;
  logic [2:0]  stored_baud;
  logic [15:0] stored_tbase;
  int          err_total = 0;
  int          checks = 0;
  int          nv_cnt = 0;
  int          n;

  always #25 hclk = ~hclk;
  assign hready = hreadyout;
  always @(posedge hclk) if (nv_we === 1'b1) nv_cnt++;

  rim_core #(.WDOG_CYCLES(200)) i_rim_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .din(din), .line_rx(line_rx), .line_tx(line_tx),
    .line_de(line_de), .nv_addr(8'h00), .nv_baud(3'h7),
    .nv_tbase(16'h039A), .nv_we(nv_we), .stored_addr(stored_addr),
    .stored_baud(stored_baud), .stored_tbase(stored_tbase),
    .irq(irq), .wdog_reset(wdog_reset));
  rim_host_model i_rim_host_model (
    .line_tx(line_tx), .line_de(line_de), .line_rx(line_rx));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One single transfer; entered just after a rising edge
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rd & m, e);
  endtask
  // Poll a field until it matches, bounded
  task automatic wt(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    n = 0;
    do begin
      bus(a, 1'b0, 32'h0);
      n++;
    end while ((rd & m) !== e && n < 15000);
    chk(rd & m, e);
  endtask
  task automatic rx_char(input logic [6:0] c, input logic bad);
    i_rim_host_model.send(c, bad);
    @(posedge hclk);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #5_000_000;
    err_total++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({29'h0, stored_baud}, 32'h7);
    chk({16'h0, stored_tbase}, 32'h39A);
    rdc(`RIM_A_STAT, 32'h8, 32'h0);
    rdc(8'h80, 32'hFFFF_FFFF, 32'h0);
    bus(`RIM_A_ADDR, 1'b1, 32'h5A);
    rdc(`RIM_A_STAT, 32'h8, 32'h8);
    chk(nv_cnt, 32'h1);
    chk({24'h0, stored_addr}, 32'h5A);
    for (int b = 0; b < 8; b++) begin
      bus(`RIM_A_BAUD, 1'b1, 32'(b));
      rdc(`RIM_A_BAUD, 32'h7, 32'(b));
      chk({29'h0, stored_baud}, 32'(b));
    end
    bus(`RIM_A_TB, 1'b1, 32'h0);
    bus(`RIM_A_TB, 1'b1, 32'h39A);
    rdc(`RIM_A_TB, 32'hFFFF, 32'h39A);
    // Serial receive, refusal before a command, then one reply
    bus(`RIM_A_IMASK, 1'b1, 32'h2);
    rx_char(7'h59, 1'b0);
    wt(`RIM_A_STAT, 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdc(`RIM_A_DATA, 32'h7F, 32'h59);
    rdc(`RIM_A_STAT, 32'h5, 32'h0);
    bus(`RIM_A_DATA, 1'b1, 32'h4E);
    rx_char(7'h51, 1'b1);
    wt(`RIM_A_ISTAT, 32'h4, 32'h4);
    chk(i_rim_host_model.got_cnt, 32'h0);
    rx_char(`RIM_CR, 1'b0);
    wt(`RIM_A_STAT, 32'h4, 32'h4);
    bus(`RIM_A_DATA, 1'b1, 32'h4E);
    n = 0;
    while (i_rim_host_model.got_cnt == 0 && n < 10000) begin
      @(posedge hclk);
      n++;
    end
    chk({25'h0, i_rim_host_model.got_char}, 32'h4E);
    chk(i_rim_host_model.bad_cnt, 32'h0);
    // Inputs, edges, change flag and counters
    bus(`RIM_A_COS_LO, 1'b1, 32'h2000);
    bus(`RIM_A_IMASK, 1'b1, 32'h1);
    wt(`RIM_A_IN_HI, 32'h20_0000, 32'h20_0000);
    bus(`RIM_A_ISTAT, 1'b1, 32'h7);
    bus(`RIM_A_FLAG, 1'b0, 32'h0);
    din <= 54'h20_0100_0000_2001;
    wt(`RIM_A_IN_LO, 32'hFFFF_FFFF, 32'h2001);
    rdc(`RIM_A_IN_HI, 32'h3F_FFFF, 32'h20_0100);
    rdc(`RIM_A_FLAG, 32'h1, 32'h1);
    rdc(`RIM_A_FLAG, 32'h1, 32'h0);
    chk({31'h0, irq}, 32'h1);
    bus(`RIM_A_IMASK, 1'b1, 32'h0);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    bus(`RIM_A_ISTAT, 1'b1, 32'h1);
    rdc(`RIM_A_ISTAT, 32'h1, 32'h0);
    bus(`RIM_A_CNT, 1'b1, 32'h0);
    rdc(`RIM_A_CNT, 32'h1_3FFF, 32'h1_0001);
    bus(`RIM_A_CNT, 1'b1, 32'd40);
    rdc(`RIM_A_CNT, 32'h3FFF, 32'h2801);
    bus(`RIM_A_CNT, 1'b1, 32'd53);
    rdc(`RIM_A_CNT, 32'hFF, 32'h0);
    bus(`RIM_A_EDG_LO, 1'b1, 32'hFFFF_FFFE);
    din <= 54'h20_0000_0000_2000;
    wt(`RIM_A_IN_LO, 32'hFFFF_FFFF, 32'h2000);
    rdc(`RIM_A_FLAG, 32'h1, 32'h0);
    bus(`RIM_A_CNT, 1'b1, 32'h0);
    rdc(`RIM_A_CNT, 32'hFF, 32'h2);
    bus(`RIM_A_CNT, 1'b1, 32'd40);
    rdc(`RIM_A_CNT, 32'hFF, 32'h1);
    bus(`RIM_A_CNT, 1'b1, 32'h100);
    rdc(`RIM_A_CNT, 32'hFF, 32'h0);
    bus(`RIM_A_CNT, 1'b1, 32'h228);
    rdc(`RIM_A_CNT, 32'hFF, 32'h0);
    // History holds the two changed samples, oldest first
    rdc(`RIM_A_HLO, 32'hFFFF_FFFF, 32'h2001);
    rdc(`RIM_A_HHI, 32'hFFFF_FFFF, 32'h8020_0100);
    rdc(`RIM_A_HLO, 32'hFFFF_FFFF, 32'h2000);
    // Watchdog restarts on a kick and expires after its count
    bus(`RIM_A_KICK, 1'b1, 32'h0);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (wdog_reset !== 1'b1 && n < 400);
    chk({31'h0, n > 189 && n < 211}, 32'h1);
    report_and_stop();
  end
endmodule // remote_input_monitor_tb_top
`default_nettype wire
